// ==== rtl/usb_bulkin_burst_detach_cfg.sv ====
// Configuration, detach timing and bulk-in burst/short-packet pacing logic.
`timescale 1ns/100ps
module usb_bulkin_burst_detach_cfg (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Avalon-MM slave
  input  wire logic [7:0]                avsAddress,
  input  wire logic                      avsRead,
  input  wire logic                      avsWrite,
  input  wire logic [3:0]                avsByteEnable,
  input  wire logic [31:0]               avsWriteData,
  output logic [31:0]                    avsReadData,
  output logic                           avsWaitRequest,
  // Configuration image sources
  input  wire logic                      eepromPresent,
  input  wire logic                      otpProgrammed,
  input  wire logic [ubc_pkg::UBC_IMG_W-1:0] eepromImage,
  input  wire logic [ubc_pkg::UBC_IMG_W-1:0] otpImage,
  input  wire logic                      imageLoad,
  // Core events and link speed
  input  wire logic                      usbReset,
  input  wire logic                      liteReset,
  input  wire logic                      softResetReq,
  input  wire ubc_pkg::ubc_speed_t       linkSpeed,
  // Bulk-in transmitter handshake
  input  wire logic                      txDataValid,
  input  wire logic                      txDataLast,
  input  wire logic [10:0]               txDataBytes,
  input  wire logic                      txMaxPacket,
  output logic                           txDataReady,
  output logic                           txSendZlp,
  output logic                           txShortGo,
  // Timing selections and detach
  output logic                           busDetached,
  output logic                           hsScaleNonSuspend,
  output logic                           hsScaleSuspend,
  output logic [16:0]                    ssTxEqCount,
  output logic [9:0]                     ssPollBurstNs,
  output logic [6:0]                     ssWarmResetUs,
  output logic                           cfgBitA,
  output logic                           cfgBitB,
  output logic [2:0]                     hsTimeoutCal,
  output logic [2:0]                     fsTimeoutCal
);
  import ubc_pkg::*;

  function automatic logic [31:0] ubcMerge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : ubcMerge

  //////////////////////////////////////////////////////////////////////////////
  // Image selection and register state

  logic [UBC_IMG_W-1:0] imageQ;
  logic [UBC_IMG_W-1:0] imageD;
  logic [1:0]           scaleQ;
  logic                 capEnQ;
  logic                 bitAQ;
  logic                 bitBQ;
  logic [2:0]           hsCalQ;
  logic [2:0]           fsCalQ;
  logic [15:0]          ssDetQ;
  logic [15:0]          hsDetQ;
  logic [7:0]           burstQ;
  logic [15:0]          delayQ;
  logic                 wrEn;
  logic [31:0]          wrVal;
  logic                 rstImg;

  always_comb begin
    if (eepromPresent) begin
      imageD = eepromImage; // see [RULE6]
    end else if (otpProgrammed) begin
      imageD = otpImage;
    end else begin
      imageD = {UBC_SS_DETACH_DEF, UBC_HIGHSPEED_DETACH_MS_DEF, UBC_CAL_DEF, UBC_CAL_DEF,
                UBC_BITB_DEF, UBC_BITA_DEF}; // see [RULE8] see [RULE9] see [RULE12]
    end
  end

  // The captured image is kept so later USB resets restore it without a reload.
  always_ff @(posedge clk) begin
    if (sys_rst || imageLoad) begin
      imageQ <= imageD;
    end
  end

  assign rstImg = usbReset || liteReset; // see [RULE7]
  assign wrEn   = avsWrite;
  assign wrVal  = ubcMerge(32'h0, avsWriteData, avsByteEnable);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scaleQ <= UBC_SCALE_RST; // see [RULE1]
      capEnQ <= 1'b0;
    end else if (wrEn && avsAddress == UBC_OFS_CFG0) begin
      if (avsByteEnable[0]) begin
        scaleQ <= avsWriteData[1:0];
        capEnQ <= avsWriteData[2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || rstImg) begin
      // Reset path uses the freshly selected image, later resets the stored one.
      {ssDetQ, hsDetQ, fsCalQ, hsCalQ, bitBQ, bitAQ} <= sys_rst ? imageD : imageQ; // see [RULE7]
    end else if (wrEn && avsAddress == UBC_OFS_DETACH) begin
      {ssDetQ, hsDetQ} <= ubcMerge({ssDetQ, hsDetQ}, avsWriteData, avsByteEnable);
    end else if (wrEn && avsAddress == UBC_OFS_CFG1 && avsByteEnable[0]) begin
      {fsCalQ, hsCalQ, bitBQ, bitAQ} <= avsWriteData[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      burstQ <= UBC_BURST_RST;
      delayQ <= UBC_DELAY_RST; // see [RULE19]
    end else if (wrEn && avsAddress == UBC_OFS_BURST && avsByteEnable[0]) begin
      burstQ <= avsWriteData[7:0]; // see [RULE20]
    end else if (wrEn && avsAddress == UBC_OFS_DELAY) begin
      delayQ <= wrVal[15:0] | (delayQ & ~{{8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}});
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Avalon-MM read path: one wait cycle for reads, writes taken at once

  logic        rdPendQ;
  logic [31:0] rdMux;
  logic        detachQ;

  always_comb begin
    rdMux = 32'h0;
    unique case (avsAddress)
      UBC_OFS_CFG0:   rdMux = {29'h0, capEnQ, scaleQ};
      UBC_OFS_CFG1:   rdMux = {24'h0, fsCalQ, hsCalQ, bitBQ, bitAQ};
      UBC_OFS_DETACH: rdMux = {ssDetQ, hsDetQ};
      UBC_OFS_STATUS: rdMux = {31'h0, detachQ};
      UBC_OFS_BURST:  rdMux = {24'h0, burstQ}; // see [RULE20]
      UBC_OFS_DELAY:  rdMux = {16'h0, delayQ};
      default:        rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdPendQ     <= 1'b0;
      avsReadData <= 32'h0;
    end else begin
      rdPendQ <= avsRead && !rdPendQ;
      if (avsRead && !rdPendQ) begin
        avsReadData <= rdMux;
      end
    end
  end

  assign avsWaitRequest = avsRead && !rdPendQ;

  //////////////////////////////////////////////////////////////////////////////
  // Scale-down timing selections

  assign hsScaleNonSuspend = scaleQ[0]; // see [RULE2]
  assign hsScaleSuspend    = scaleQ[1];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ssTxEqCount   <= 17'(UBC_SS_TXEQ_REAL);
      ssPollBurstNs <= 10'(UBC_POLL_NS_REAL);
      ssWarmResetUs <= 7'(UBC_WARM_US_REAL);
    end else begin
      ssTxEqCount   <= scaleQ[1] ? 17'h0 :
                       scaleQ[0] ? 17'(UBC_SS_TXEQ_SCALE) : 17'(UBC_SS_TXEQ_REAL); // see [RULE4]
      ssPollBurstNs <= scaleQ[0] ? 10'(UBC_POLL_NS_SCALE) : 10'(UBC_POLL_NS_REAL); // see [RULE3]
      ssWarmResetUs <= scaleQ[0] ? 7'(UBC_WARM_US_SCALE) : 7'(UBC_WARM_US_REAL);
    end
  end

  assign cfgBitA      = bitAQ;
  assign cfgBitB      = bitBQ;
  assign hsTimeoutCal = hsCalQ;
  assign fsTimeoutCal = fsCalQ;

  //////////////////////////////////////////////////////////////////////////////
  // Soft-reset detach timer: a 1 ms tick and a millisecond down-counter

  logic [15:0] msTickQ;
  logic [15:0] detMsQ;
  logic        msTick;

  assign msTick = (msTickQ == 16'(UBC_MS_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (sys_rst || softResetReq || msTick) begin
      msTickQ <= 16'h0;
    end else begin
      msTickQ <= msTickQ + 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      detachQ <= 1'b0;
      detMsQ  <= 16'h0;
    end else if (softResetReq) begin
      detMsQ  <= (linkSpeed == UBC_SPD_SS) ? ssDetQ : hsDetQ; // see [RULE10] see [RULE11]
      detachQ <= ((linkSpeed == UBC_SPD_SS) ? ssDetQ : hsDetQ) != 16'h0;
    end else if (detachQ && msTick) begin
      detMsQ <= detMsQ - 16'h1;
      if (detMsQ == 16'h1) begin
        detachQ <= 1'b0;
      end
    end
  end

  assign busDetached = detachQ;

  //////////////////////////////////////////////////////////////////////////////
  // Bulk-in bulk_in_burst_limit and short-packet delay

  ubc_tx_t     txStQ;
  logic [19:0] burstBytesQ;
  logic [19:0] capBytes;
  logic        capActive;
  logic [31:0] dlyCntQ;
  logic [31:0] dlyTarget;
  logic        pendZlpQ;

  always_comb begin
    unique case (linkSpeed)
      UBC_SPD_SS: capBytes = 20'(int'(burstQ) * UBC_UNIT_SS); // see [RULE14]
      UBC_SPD_HS: capBytes = 20'(int'(burstQ) * UBC_UNIT_HS);
      default:    capBytes = 20'(int'(burstQ) * UBC_UNIT_FS);
    endcase
  end

  assign capActive = capEnQ && (capBytes > UBC_CAP_MIN); // see [RULE15] see [RULE16]
  // Steps of 16.667 ns converted to 20 ns clock cycles, rounded up.
  assign dlyTarget = 32'((64'(delayQ) * UBC_DLY_STEP_PS + UBC_CLK_PS - 1) / UBC_CLK_PS);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txStQ       <= UBC_TX_IDLE;
      burstBytesQ <= 20'h0;
      dlyCntQ     <= 32'h0;
      pendZlpQ    <= 1'b0;
      txSendZlp   <= 1'b0;
      txShortGo   <= 1'b0;
    end else begin
      txSendZlp <= 1'b0;
      txShortGo <= 1'b0;
      unique case (txStQ)
        UBC_TX_IDLE: begin
          if (txDataValid && txMaxPacket && !txDataLast) begin
            // Full packets flow immediately and count toward the cap.
            if (capActive && (burstBytesQ + 20'(txDataBytes)) >= capBytes) begin
              pendZlpQ    <= 1'b1; // see [RULE13]
              burstBytesQ <= 20'h0;
              dlyCntQ     <= 32'h0;
              txStQ       <= UBC_TX_WAIT;
            end else begin
              burstBytesQ <= burstBytesQ + 20'(txDataBytes);
            end
          end else if (txDataValid) begin
            pendZlpQ    <= 1'b0;
            burstBytesQ <= 20'h0;
            dlyCntQ     <= 32'h0;
            txStQ       <= UBC_TX_WAIT;
          end
        end
        UBC_TX_WAIT: begin
          if (dlyCntQ >= dlyTarget) begin
            txStQ <= UBC_TX_SEND; // see [RULE18]
          end else begin
            dlyCntQ <= dlyCntQ + 32'h1;
          end
        end
        UBC_TX_SEND: begin
          txSendZlp <= pendZlpQ;
          txShortGo <= !pendZlpQ;
          txStQ     <= UBC_TX_IDLE;
        end
      endcase
    end
  end

  // Full packets pass in IDLE; short ones are held until the delay expires.
  assign txDataReady = (txStQ == UBC_TX_IDLE && txMaxPacket && !txDataLast) ||
                       (txStQ == UBC_TX_SEND && !pendZlpQ);
endmodule : usb_bulkin_burst_detach_cfg

// ==== rtl/ubc_pkg.sv ====
// Package of constants for the bulk-in burst, detach and configuration block.
//
// What this block does
// [RULE1] Two-bit scale-down selector, reset zero, real timing.
// [RULE2] HS/FS: 01 non-suspend, 10 suspend, 11 both.
// [RULE3] SS 01: eight TxEq, 100 ns poll, 30 us.
// [RULE4] SS 10: no TxEq sequences, overrides training.
// [RULE5] Software keeps selector zero outside simulation.
// [RULE6] Defaults from EEPROM, else OTP, else fallback.
// [RULE7] USB or lite reset restores last image value.
// [RULE8] Two config-zero bits fall back to 0, 1.
// [RULE9] Timeout calibration fields fall back to zero.
// [RULE10] SuperSpeed soft reset detaches upper-field milliseconds.
// [RULE11] High/full speed detaches lower-field milliseconds.
// [RULE12] Detach fallbacks 0x1E SS, 0x0A HS.
// [RULE13] Bulk_in_burst_limit reached ends burst with ZLP.
// [RULE14] Cap units 1024 SS, 512 HS, 64 FS.
// [RULE15] Cap acts only when enable bit set.
// [RULE16] Cap at most 2048 bytes is ignored.
// [RULE17] Software sets cap at least max frame size.
// [RULE18] Wait bulk-in delay before short or ZLP.
// [RULE19] Delay steps 16.667 ns, reset 0800h.
// [RULE20] Reserved bits read zero, ignore writes.
package ubc_pkg;
  localparam logic [7:0]  UBC_OFS_CFG0      = 8'h80;
  localparam logic [7:0]  UBC_OFS_CFG1      = 8'h84;
  localparam logic [7:0]  UBC_OFS_DETACH    = 8'h88;
  localparam logic [7:0]  UBC_OFS_BURST     = 8'h90;
  localparam logic [7:0]  UBC_OFS_DELAY     = 8'h94;
  localparam logic [7:0]  UBC_OFS_STATUS    = 8'h8c;

  localparam logic [1:0]  UBC_SCALE_RST     = 2'h0;
  localparam logic [15:0] UBC_SS_DETACH_DEF = 16'h001e;
  localparam logic [15:0] UBC_HIGHSPEED_DETACH_MS_DEF = 16'h000a;
  localparam logic [2:0]  UBC_CAL_DEF       = 3'h0;
  localparam logic        UBC_BITA_DEF      = 1'b0;
  localparam logic        UBC_BITB_DEF      = 1'b1;
  localparam logic [7:0]  UBC_BURST_RST     = 8'h00;
  localparam logic [15:0] UBC_DELAY_RST     = 16'h0800;

  // Image layout: [0]=bitA [1]=bitB [4:2]=hsCal [7:5]=fsCal [23:8]=hsDet [39:24]=ssDet.
  localparam int          UBC_IMG_W         = 40;

  localparam int          UBC_UNIT_SS       = 1024;
  localparam int          UBC_UNIT_HS       = 512;
  localparam int          UBC_UNIT_FS       = 64;
  localparam logic [19:0] UBC_CAP_MIN       = 20'd2048;

  localparam int          UBC_CLK_KHZ       = 50000;
  localparam int          UBC_DLY_STEP_PS   = 16667;
  localparam int          UBC_CLK_PS        = 20000;
  localparam int          UBC_MS_CYCLES     = UBC_CLK_KHZ;
  localparam int          UBC_SS_TXEQ_REAL  = 65536;
  localparam int          UBC_SS_TXEQ_SCALE = 8;
  localparam int          UBC_POLL_NS_REAL  = 1000;
  localparam int          UBC_POLL_NS_SCALE = 100;
  localparam int          UBC_WARM_US_REAL  = 80;
  localparam int          UBC_WARM_US_SCALE = 30;

  typedef enum logic [1:0] {UBC_SPD_FS, UBC_SPD_HS, UBC_SPD_SS} ubc_speed_t;
  typedef enum logic [1:0] {UBC_TX_IDLE, UBC_TX_WAIT, UBC_TX_SEND} ubc_tx_t;
endpackage : ubc_pkg

// ==== test/ubc_chk.sv ====
// Port-level assertions for the configuration, detach and bulk-in pacing block.
`timescale 1ns/100ps
module ubc_chk
  import ubc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic        avsWaitRequest,
  // Image sources and events
  input wire logic        eepromPresent,
  input wire logic        otpProgrammed,
  input wire logic        softResetReq,
  // Observed outputs
  input wire logic        txSendZlp,
  input wire logic        txShortGo,
  input wire logic        txDataReady,
  input wire logic        busDetached,
  input wire logic        hsScaleNonSuspend,
  input wire logic        hsScaleSuspend,
  input wire logic [16:0] ssTxEqCount,
  input wire logic [9:0]  ssPollBurstNs,
  input wire logic [6:0]  ssWarmResetUs,
  input wire logic        cfgBitA,
  input wire logic        cfgBitB,
  input wire logic [2:0]  hsTimeoutCal
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence readAnswer;
    avsWaitRequest ##1 !avsWaitRequest;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // The selector is checked only once stable, so either output latency passes.
  txeq_scale_a: assert property ($stable(hsScaleSuspend) && $stable(hsScaleNonSuspend) |->
    ssTxEqCount == (hsScaleSuspend ? 17'h0 : hsScaleNonSuspend ? 17'(UBC_SS_TXEQ_SCALE) :
    17'(UBC_SS_TXEQ_REAL))) else $error("training count does not follow selector");
  poll_scale_a: assert property ($stable(hsScaleNonSuspend) |-> ssPollBurstNs ==
    (hsScaleNonSuspend ? 10'(UBC_POLL_NS_SCALE) : 10'(UBC_POLL_NS_REAL)))
    else $error("poll burst does not follow selector");
  warm_scale_a: assert property ($stable(hsScaleNonSuspend) |-> ssWarmResetUs ==
    (hsScaleNonSuspend ? 7'(UBC_WARM_US_SCALE) : 7'(UBC_WARM_US_REAL)))
    else $error("warm reset time does not follow selector");
  write_nowait_a: assert property (avsWrite |-> !avsWaitRequest)
    else $error("write stalled");
  read_wait_a: assert property ($rose(avsRead) |-> readAnswer)
    else $error("read answer timing wrong");
  zlp_pulse_a: assert property (txSendZlp |=> !txSendZlp)
    else $error("zero length marker longer than one cycle");
  shortgo_cause_a: assert property (txShortGo |-> $past(txDataReady) && !$past(txShortGo))
    else $error("short packet release without handoff");
  detach_cause_a: assert property ($rose(busDetached) |-> $past(softResetReq))
    else $error("detach without soft reset request");
  image_fallback_a: assert property ($past(sys_rst) && !eepromPresent && !otpProgrammed |->
    !cfgBitA && cfgBitB && hsTimeoutCal == 3'h0) else $error("fallback bits wrong");
endmodule : ubc_chk

bind usb_bulkin_burst_detach_cfg ubc_chk chk_u (.*);

// ==== test/ubc_host_model.sv ====
// Far side of the bulk-in handshake: offers packets and counts end markers.
`timescale 1ns/100ps
module ubc_host_model (
  // Clock
  input  wire logic        clk,
  // Packet offer
  output logic             txDataValid,
  output logic             txDataLast,
  output logic [10:0]      txDataBytes,
  output logic             txMaxPacket,
  // Answers
  input  wire logic        txDataReady,
  input  wire logic        txSendZlp,
  input  wire logic        txShortGo
);
  int zlpCnt = 0;
  int shortCnt = 0;
  initial begin
    txDataValid = 1'b0;
    txDataLast = 1'b0;
    txDataBytes = 11'h7ff;
    txMaxPacket = 1'b0;
  end
  always @(posedge clk) begin
    if (txSendZlp) zlpCnt <= zlpCnt + 1;
    if (txShortGo) shortCnt <= shortCnt + 1;
  end
  // Packet sizes never exceed the programmed limit, so the limit covers a frame.
  task automatic send(input logic [10:0] n, input logic last, output int lat);
    lat = 0;
    @(posedge clk);
    txDataValid <= 1'b1;
    txDataLast <= last;
    txMaxPacket <= !last;
    txDataBytes <= n;
    do begin
      @(posedge clk);
      lat++;
    end while (txDataReady !== 1'b1);
    // A released count shows the inverse, so stale data is never mistaken.
    txDataValid <= 1'b0;
    txDataBytes <= ~n;
  endtask : send
endmodule : ubc_host_model

// ==== test/usb_bulkin_burst_detach_cfg_tb.sv ====
// Self-checking bench for the configuration, detach and bulk-in pacing block.
`timescale 1ns/100ps
module usb_bulkin_burst_detach_cfg_tb;
  import ubc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avsAddress = 8'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic eepromPresent = 1'b0;
  logic otpProgrammed = 1'b0;
  logic [UBC_IMG_W-1:0] eepromImage = '0;
  logic [UBC_IMG_W-1:0] otpImage = '0;
  logic [3:0] ev = 4'h0;
  ubc_speed_t linkSpeed = UBC_SPD_HS;
  logic txDataValid, txDataLast, txMaxPacket, txDataReady, txSendZlp, txShortGo;
  logic [10:0] txDataBytes;
  logic busDetached, hsScaleNonSuspend, hsScaleSuspend, cfgBitA, cfgBitB;
  logic [16:0] ssTxEqCount;
  logic [9:0] ssPollBurstNs;
  logic [6:0] ssWarmResetUs;
  logic [2:0] hsTimeoutCal, fsTimeoutCal;
  logic [7:0] cfgView;
  logic [7:0] rAddr [7] = '{8'h88, 8'h90, 8'h94, 8'h80, 8'h84, 8'h8c, 8'ha0};
  logic [31:0] rExp [7] = '{32'h001e000a, 32'h0, 32'h0800, 32'h0, 32'h2, 32'h0, 32'h0};
  int errorCnt = 0;
  int cmpCount = 0;
  assign cfgView = {fsTimeoutCal, hsTimeoutCal, cfgBitB, cfgBitA};
  usb_bulkin_burst_detach_cfg dut_u (.*, .avsByteEnable(4'hf), .imageLoad(ev[0]),
    .usbReset(ev[1]), .liteReset(ev[2]), .softResetReq(ev[3]));
  ubc_host_model host_u (.*);
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic endSim;
    if (errorCnt == 0 && cmpCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : endSim
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmpCount++;
    if (s !== e) begin
      errorCnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= 1'b1;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    avsWrite <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    avsAddress <= a;
    avsRead <= 1'b1;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    avsRead <= 1'b0;
    chk($sformatf("register %h", a), e, avsReadData);
  endtask : rc
  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 4'(1 << i);
    @(posedge clk);
    ev <= 4'h0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    errorCnt++;
    endSim();
  end
  initial begin
    int lat;
    int z0;
    int u;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rAddr[i]) rc(rAddr[i], rExp[i]);
    wr(UBC_OFS_BURST, 32'hffffffff);
    rc(UBC_OFS_BURST, 32'hff);
    wr(UBC_OFS_DELAY, 32'hffffffff);
    rc(UBC_OFS_DELAY, 32'hffff);
    wr(UBC_OFS_DELAY, 32'd12);
    for (int s = 0; s < 4; s++) begin
      wr(UBC_OFS_CFG0, 32'(s));
      repeat (2) @(negedge clk);
      chk("scale", 32'(s), {30'h0, hsScaleSuspend, hsScaleNonSuspend});
      chk("txeq", s[1] ? 0 : s[0] ? UBC_SS_TXEQ_SCALE : UBC_SS_TXEQ_REAL, 32'(ssTxEqCount));
      chk("poll", s[0] ? UBC_POLL_NS_SCALE : UBC_POLL_NS_REAL, 32'(ssPollBurstNs));
      chk("warm", s[0] ? UBC_WARM_US_SCALE : UBC_WARM_US_REAL, 32'(ssWarmResetUs));
    end
    wr(UBC_OFS_CFG0, 32'h0);
    otpImage <= 40'h0003_0004_ab;
    otpProgrammed <= 1'b1;
    pulse(0);
    pulse(1);
    rc(UBC_OFS_DETACH, 32'h0003_0004);
    chk("otp bits", 32'hab, 32'(cfgView));
    eepromImage <= 40'h0007_0009_00;
    eepromPresent <= 1'b1;
    pulse(0);
    for (int r = 1; r < 3; r++) begin
      wr(UBC_OFS_DETACH, 32'h1234_5678);
      wr(UBC_OFS_CFG1, 32'hff);
      pulse(r);
      rc(UBC_OFS_DETACH, 32'h0007_0009);
      chk("restored bits", 32'h0, 32'(cfgView));
    end
    eepromPresent <= 1'b0;
    otpProgrammed <= 1'b0;
    pulse(0);
    pulse(2);
    rc(UBC_OFS_DETACH, 32'h001e_000a);
    chk("fallback bits", 32'h2, 32'(cfgView));
    wr(UBC_OFS_DETACH, 32'h0000_0001);
    pulse(3);
    @(negedge clk);
    chk("detached", 32'h1, 32'(busDetached));
    repeat (UBC_MS_CYCLES - 1000) @(negedge clk);
    chk("still detached", 32'h1, 32'(busDetached));
    repeat (2000) @(negedge clk);
    chk("attached", 32'h0, 32'(busDetached));
    linkSpeed <= UBC_SPD_SS;
    wr(UBC_OFS_DETACH, 32'h0000_0005);
    pulse(3);
    repeat (3) @(negedge clk);
    chk("zero detach", 32'h0, 32'(busDetached));
    wr(UBC_OFS_DETACH, 32'h0001_0000);
    pulse(3);
    @(negedge clk);
    chk("ss detached", 32'h1, 32'(busDetached));
    linkSpeed <= UBC_SPD_HS;
    z0 = host_u.shortCnt;
    host_u.send(11'd100, 1'b1, lat);
    chk("short wait", (12 * UBC_DLY_STEP_PS + UBC_CLK_PS - 1) / UBC_CLK_PS + 3, lat);
    repeat (3) @(negedge clk);
    chk("short release", z0 + 1, host_u.shortCnt);
    wr(UBC_OFS_CFG0, 32'h4);
    for (int k = 0; k < 3; k++) begin
      u = k == 2 ? UBC_UNIT_SS : k == 1 ? UBC_UNIT_HS : UBC_UNIT_FS;
      linkSpeed <= ubc_speed_t'(k);
      wr(UBC_OFS_BURST, 32'(2048 / u + 1));
      z0 = host_u.zlpCnt;
      for (int p = 0; p <= 2048 / u; p++) begin
        if (p == 2048 / u) chk("early zlp", z0, host_u.zlpCnt);
        host_u.send(11'(u), 1'b0, lat);
      end
      repeat (20) @(negedge clk);
      chk("zlp at cap", z0 + 1, host_u.zlpCnt);
    end
    linkSpeed <= UBC_SPD_HS;
    for (int j = 0; j < 2; j++) begin
      wr(UBC_OFS_CFG0, j ? 32'h0 : 32'h4);
      wr(UBC_OFS_BURST, 32'(4 + j));
      z0 = host_u.zlpCnt;
      repeat (6) host_u.send(11'd512, 1'b0, lat);
      repeat (20) @(negedge clk);
      chk("cap ignored", z0, host_u.zlpCnt);
    end
    endSim();
  end
endmodule : usb_bulkin_burst_detach_cfg_tb
